/* File: hw/raster_pkg.sv */
// shared constants and carrier types for the interlaced raster timing generator
// assumes one clock edge per picture element from the display oscillator
package raster_pkg;

    // raster geometry
    localparam logic [9:0] H_TOTAL      = 10'd780;
    localparam logic [9:0] H_ACTIVE     = 10'd640;
    localparam logic [9:0] H_HALF       = 10'd390;
    localparam logic [9:0] HSYNC_START  = 10'd656;
    localparam logic [9:0] HSYNC_END    = 10'd716;
    localparam logic [9:0] V_TOTAL      = 10'd525;
    localparam logic [9:0] FIELD1_LINES = 10'd262;
    localparam logic [9:0] V_PER_FIELD  = 10'd240;
    localparam logic [9:0] V1_FIRST     = 10'd20;
    localparam logic [9:0] V0_FIRST     = 10'd283;

    // rates
    localparam int unsigned FRAME_RATE_HZ = 30;
    localparam int unsigned FIELD_RATE_HZ = 2 * FRAME_RATE_HZ;
    localparam int unsigned LINE_RATE_HZ  = 15750;
    localparam int unsigned OSC_HZ        = 780 * LINE_RATE_HZ;

    // vertical sync length in half lines, and in clock cycles
    localparam logic [2:0] VSYNC_HALVES = 3'd6;
    localparam int         VS_CYCLES    = 6 * 390;

    // processor master clock: half period in oscillator cycles
    localparam logic [1:0] CPU_HALF     = 2'd2;

    // after reset
    localparam logic       FIELD_RESET  = 1'b1;

    // video level, one-hot
    typedef enum logic [2:0] {
        LV_SYNC  = 3'b001,
        LV_BLANK = 3'b010,
        LV_VIDEO = 3'b100
    } level_t;

    typedef struct packed {
        level_t     level;
        logic [3:0] grey;
    } composite_t;

    typedef struct packed {
        logic [9:0] h;
        logic [9:0] line;
        logic       field;
    } raster_pos_t;

endpackage : raster_pkg

/* File: hw/raster_timing.sv */
// interlaced raster timing and composite video generator
// assumes clk is the picture element oscillator, reset_n synchronous active low
//
// What this block does
// - a frame holds 525 scan lines
// - each line lasts 780 picture element periods, retrace included
// - visible window is 480 lines by 640 elements, all else blank
// - full raster repeats thirty times per second
// - vertical sync at twice frame rate, two interlaced fields per frame
// - one composite output carrying pixels, blanking and both syncs
// - video held blank during horizontal and vertical retrace
// - one oscillator derives display timing, syncs and processor master clock
// - each field is 262 and a half lines, switching at mid-line
// - field indicator reads 1 in first field, 0 in second
// - character cell is 8 elements wide, 16 lines from both fields
`timescale 1ns/1ps
module raster_timing
    import raster_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  pixel_grey,
    output raster_pos_t      pos,
    output logic             active,
    output logic             cell_fetch,
    output logic [6:0]       cell_col,
    output logic [3:0]       cell_row,
    output logic             hsync,
    output logic             vsync,
    output composite_t       video,
    output logic             cpu_clk
);

    ////////////////////////////////////////////////////////////////////////
    // counters

    logic [9:0] h_q;
    logic [9:0] line_q;
    logic       field_q;
    logic [2:0] vs_cnt_q;
    logic [1:0] cpu_cnt_q;
    logic       cpu_clk_q;
    composite_t video_q;

    logic       h_last;
    logic       frame_end;
    logic       mid_switch;
    logic       half_edge;
    logic       vis_v;
    logic [9:0] v_rel;

    assign h_last     = (h_q == H_TOTAL - 10'd1);
    assign frame_end  = h_last && (line_q == V_TOTAL - 10'd1);
    // second field starts halfway through line 262
    assign mid_switch = (line_q == FIELD1_LINES) && (h_q == H_HALF - 10'd1);
    assign half_edge  = h_last || (h_q == H_HALF - 10'd1);

    // picture element counter, one element per oscillator cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            h_q <= 10'd0;
        end else if (h_last) begin
            h_q <= 10'd0;
        end else begin
            h_q <= h_q + 10'd1;
        end
    end

    // frame line counter across both fields; 780 x 525 x 30 sets the oscillator rate
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            line_q <= 10'd0;
        end else if (frame_end) begin
            line_q <= 10'd0;
        end else if (h_last) begin
            line_q <= line_q + 10'd1;
        end
    end

    // field indicator
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            field_q <= FIELD_RESET;
        end else if (frame_end) begin
            field_q <= 1'b1;
        end else if (mid_switch) begin
            field_q <= 1'b0;
        end
    end

    // vertical sync counts half lines so both fields see the same pulse length
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vs_cnt_q <= VSYNC_HALVES;
        end else if (frame_end || mid_switch) begin
            vs_cnt_q <= VSYNC_HALVES;
        end else if (half_edge && vs_cnt_q != 3'd0) begin
            vs_cnt_q <= vs_cnt_q - 3'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    // visible lines: 240 per field, offset by half a line between fields
    assign v_rel  = line_q - (field_q ? V1_FIRST : V0_FIRST);
    assign vis_v  = (v_rel < V_PER_FIELD);
    assign active = (h_q < H_ACTIVE) && vis_v;
    assign hsync  = (h_q >= HSYNC_START) && (h_q < HSYNC_END);
    assign vsync  = (vs_cnt_q != 3'd0);

    // cell fetch on the first element of each 8-wide cell
    assign cell_fetch = active && (h_q[2:0] == 3'd0);
    assign cell_col   = h_q[9:3];
    // field 1 draws even rows of the cell, field 0 the odd ones
    assign cell_row   = {v_rel[2:0], ~field_q};

    assign pos   = '{h: h_q, line: line_q, field: field_q};
    assign video = video_q;

    ////////////////////////////////////////////////////////////////////////
    // composite output, one cycle behind the position

    // pixel data is sampled straight in; the display processor must have filled the buffer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            video_q <= '{level: LV_BLANK, grey: 4'h0};
        end else if (hsync || vsync) begin
            video_q <= '{level: LV_SYNC, grey: 4'h0};
        end else if (active) begin
            video_q <= '{level: LV_VIDEO, grey: pixel_grey};
        end else begin
            video_q <= '{level: LV_BLANK, grey: 4'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // processor master clock, divided from the same oscillator

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cpu_cnt_q <= 2'd0;
            cpu_clk_q <= 1'b0;
        end else if (cpu_cnt_q == CPU_HALF - 2'd1) begin
            cpu_cnt_q <= 2'd0;
            cpu_clk_q <= ~cpu_clk_q;
        end else begin
            cpu_cnt_q <= cpu_cnt_q + 2'd1;
        end
    end

    assign cpu_clk = cpu_clk_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    int vs_len_q;

    // vsync width helper, only read by an assertion
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vs_len_q <= 0;
        end else if (vsync) begin
            vs_len_q <= vs_len_q + 1;
        end else begin
            vs_len_q <= 0;
        end
    end

    a_h_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        h_q == 10'd779 |=> h_q == 10'd0)
        else $error("line did not end after 780 elements");

    a_line_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        (h_q == 10'd779 && line_q == 10'd524) |=> (line_q == 10'd0 && h_q == 10'd0))
        else $error("frame did not end after 525 lines");

    a_line_step: assert property (@(posedge clk) disable iff (!reset_n)
        (h_q == 10'd779 && line_q != 10'd524) |=> line_q == $past(line_q) + 10'd1)
        else $error("line count did not advance at line end");

    a_active_window: assert property (@(posedge clk) disable iff (!reset_n)
        active |-> (h_q < 10'd640 && ((line_q >= 10'd20 && line_q < 10'd260 && field_q)
                                      || (line_q >= 10'd283 && line_q < 10'd523 && !field_q))))
        else $error("active outside the visible window");

    a_retrace_blank: assert property (@(posedge clk) disable iff (!reset_n)
        !active |=> (video_q.grey == 4'h0 && video_q.level != LV_VIDEO))
        else $error("video not blank during retrace");

    a_sync_level: assert property (@(posedge clk) disable iff (!reset_n)
        (hsync || vsync) |=> video_q.level == LV_SYNC)
        else $error("sync missing from composite output");

    a_field_mid: assert property (@(posedge clk) disable iff (!reset_n)
        (line_q == 10'd262 && h_q == 10'd389) |=> (!field_q && vsync))
        else $error("second field did not start mid-line");

    a_field_first: assert property (@(posedge clk) disable iff (!reset_n)
        (line_q == 10'd524 && h_q == 10'd779) |=> (field_q && vsync))
        else $error("first field indicator wrong");

    // the helper still holds the finished run length on the edge that first sees vsync low
    a_vsync_len: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vsync) |-> vs_len_q == VS_CYCLES)
        else $error("vertical sync width wrong");

    a_cpu_clock: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(cpu_clk_q) |=> $stable(cpu_clk_q) ##1 $changed(cpu_clk_q))
        else $error("processor clock cadence wrong");

    a_cell_row: assert property (@(posedge clk) disable iff (!reset_n)
        cell_fetch |-> (cell_row[0] == ~field_q && h_q[2:0] == 3'd0))
        else $error("cell row or column phase wrong");

    c_second_field: cover property (@(posedge clk) disable iff (!reset_n)
        $fell(field_q));
    c_frame_wrap: cover property (@(posedge clk) disable iff (!reset_n)
        $rose(field_q));
    c_cell_fetch: cover property (@(posedge clk) disable iff (!reset_n)
        cell_fetch && !field_q);
    c_vsync_end: cover property (@(posedge clk) disable iff (!reset_n)
        $fell(vsync));

endmodule : raster_timing

/* File: dv/crt_monitor.sv */
// monitor model: measures line period, sync width and light during sync
// assumes video lags the sync decodes by one clock
`timescale 1ns/1ps
module crt_monitor
    import raster_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic hsync,
    input  wire logic vsync,
    input  composite_t video,
    output int        line_len,
    output int        sync_len,
    output int        lit_in_retrace
);
    logic hs_q;
    logic sy_q;
    int   cnt;
    int   wid;

    ////////////////////////////////////////////////////////////////////////
    // deflection: line period from rising hsync, sync tip width
    always @(posedge clk) begin
        hs_q <= hsync;
        sy_q <= hsync | vsync;
        if (!reset_n) begin
            cnt            <= 0;
            wid            <= 0;
            lit_in_retrace <= 0;
        end else begin
            cnt <= (hsync && !hs_q) ? 1 : cnt + 1;
            wid <= hsync ? wid + 1 : 0;
            if (hsync && !hs_q) line_len <= cnt;
            if (!hsync && hs_q) sync_len <= wid;
            // the tube shows anything lit, so retrace must stay dark
            if (sy_q && video.level == LV_VIDEO) lit_in_retrace <= lit_in_retrace + 1;
        end
    end
endmodule : crt_monitor

/* File: dv/tb.sv */
// testbench for the raster timing generator
// assumes raster_pkg and raster_timing compiled first
`timescale 1ns/1ps
module tb;
    import raster_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  pixel_grey = 4'h0;
    raster_pos_t pos;
    logic        active;
    logic        cell_fetch;
    logic [6:0]  cell_col;
    logic [3:0]  cell_row;
    logic        hsync;
    logic        vsync;
    composite_t  video;
    logic        cpu_clk;
    int          line_len;
    int          sync_len;
    int          lit_in_retrace;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;

    always #50 clk = ~clk;
    // grey ramp so every element differs from its neighbour
    always @(posedge clk) pixel_grey <= pixel_grey + 4'h1;
    always @(posedge clk) cyc <= reset_n ? cyc + 1 : 0;

    raster_timing i_raster_timing (.clk(clk), .reset_n(reset_n), .pixel_grey(pixel_grey), .pos(pos),
        .active(active), .cell_fetch(cell_fetch), .cell_col(cell_col), .cell_row(cell_row),
        .hsync(hsync), .vsync(vsync), .video(video), .cpu_clk(cpu_clk));
    crt_monitor i_crt_monitor (.clk(clk), .reset_n(reset_n), .hsync(hsync), .vsync(vsync), .video(video),
        .line_len(line_len), .sync_len(sync_len), .lit_in_retrace(lit_in_retrace));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // bounded wait for the start of a given line
    task automatic wait_line(input logic [9:0] ln);
        int n;
        n = 0;
        while (!(pos.line === ln && pos.h === 10'h000) && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_line

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check(pos, {10'h000, 10'h000, FIELD_RESET});
        check(vsync, 1'b1);
        check(video.level, LV_BLANK);
        $display("test reset done");
    endtask : t_reset

    task automatic t_cpu_clk;
        logic [11:0] s;
        for (int k = 0; k < 12; k++) begin
            s[k] = cpu_clk;
            @(posedge clk);
            #1;
        end
        check(s[11:2] ^ s[9:0], 10'h3ff);
        $display("test cpu clock done");
    endtask : t_cpu_clk

    task automatic t_vsync;
        int n;
        n = 0;
        while (vsync === 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(cyc, VS_CYCLES);
        $display("test vsync done");
    endtask : t_vsync

    task automatic t_lines;
        wait_line(10'h004);
        check(line_len, 780);
        check(sync_len, 32'(HSYNC_END - HSYNC_START));
        $display("test line timing done");
    endtask : t_lines

    // one whole line: window count, cell strobes, video one cycle late
    task automatic t_line_video(input logic [9:0] ln, input int exp_act);
        int       act;
        int       fet;
        level_t   lv;
        logic [3:0] gr;
        act = 0;
        fet = 0;
        wait_line(ln);
        if (exp_act != 0) check(cell_row, {ln[2:0] - 3'h4, ~pos.field});
        for (int k = 0; k < 780; k++) begin
            lv = (hsync | vsync) ? LV_SYNC : (active ? LV_VIDEO : LV_BLANK);
            gr = (active & ~hsync & ~vsync) ? pixel_grey : 4'h0;
            if (cell_fetch === 1'b1) begin
                fet++;
                check(cell_col, k / 8);
                check(k % 8, 0);
            end
            if (active === 1'b1) act++;
            @(posedge clk);
            #1;
            check({video.level, video.grey}, {lv, gr});
        end
        check(act, exp_act);
        check(fet, exp_act / 8);
        check(pos.line, ln + 10'h001);
        $display("test line video done");
    endtask : t_line_video

    initial begin
        #(40000 * 100);
        num_errors++;
        final_report();
    end

    initial begin
        t_reset();
        t_cpu_clk();
        t_vsync();
        t_lines();
        t_line_video(10'h005, 0);
        t_line_video(10'h014, 640);
        t_line_video(10'h015, 640);
        check(lit_in_retrace, 0);
        final_report();
    end
endmodule : tb
